// ---- design/sarb_regbank.sv ----
// Secure alias register bank with attribute decode and multi-format storage
module sarb_regbank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Configuration access, same clock domain
  input wire sarb_pkg::sarb_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Non-secure fault, secure and non-secure invalidate, and translation engine status
  input wire logic [15:0] ns_fault_security_state_determination_index,
  input wire logic ns_fault_valid,
  input wire logic ns_inv_done,
  input wire logic s_inv_done,
  input wire logic ns_ats_busy,
  // Control outputs
  output logic ns_inv_issue,
  output logic s_inv_issue,
  output logic ns_sync_active,
  output logic s_sync_active,
  output logic secure_only_global_access,
  output sarb_pkg::sarb_attr_s attr_out
);
  import sarb_pkg::*;

  // ==========================================================================
  // Attribute decode
  function automatic sarb_attr_s decode_attr(input logic [3:0] code);
    sarb_attr_s a;
    a.outer = code[3:2];
    a.normal = (code[3:2] != 2'h0);
    if (!a.normal) begin
      a.inner = sarb_mtype_e'({1'b0, code[1:0]});
    end else begin
      unique case (code[1:0])
        2'h0: a.inner = SARB_NORM_RSVD;
        2'h1: a.inner = SARB_NORM_NC;
        2'h2: a.inner = SARB_NORM_WT;
        2'h3: a.inner = SARB_NORM_WB;
      endcase
    end
    return a;
  endfunction : decode_attr

  // ==========================================================================
  // Access decode
  logic gasr_r;
  logic [31:0] ns_ctrl0_r;
  logic [15:0] ssd_r;
  logic ns_sync_r;
  logic s_sync_r;
  logic ns_issue_r;
  logic s_issue_r;
  logic [31:0] mfmt_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic ats_s1_r;
  logic ats_s2_r;

  // Alias window ends below the multi-format register, which stays global
  wire is_alias = cfg_req.addr[10] && (cfg_req.addr < SARB_OFF_MFMT);
  wire global_ok = cfg_req.valid && (cfg_req.secure || !gasr_r);
  wire alias_ok = global_ok && cfg_req.secure;
  wire acc_ok = is_alias ? alias_ok : global_ok;
  wire wr = acc_ok && cfg_req.write;
  wire rd = acc_ok && !cfg_req.write;
  wire [31:0] wd = cfg_req.wdata;
  wire hit_sctrl1 = cfg_req.addr == SARB_OFF_SCTRL1 && cfg_req.secure;
  wire hit_ssync = cfg_req.addr == SARB_OFF_STLB_SYNC && cfg_req.secure;
  wire hit_sstat = cfg_req.addr == SARB_OFF_STLB_STAT && cfg_req.secure;
  wire hit_nsctrl0 = cfg_req.addr == SARB_OFF_NS_CTRL0;
  wire hit_nssyn1 = cfg_req.addr == SARB_OFF_NS_SYN1;
  wire hit_nssync = cfg_req.addr == SARB_OFF_NS_TLB_SYNC;
  wire hit_nsstat = cfg_req.addr == SARB_OFF_NS_TLB_STAT;
  wire hit_nsats = cfg_req.addr == SARB_OFF_NS_ATS_STAT;
  wire hit_mfmt = cfg_req.addr == SARB_OFF_MFMT;

  // Secure sync alias starts queued non-secure invalidates
  wire ns_sync_start = wr && hit_nssync;
  // Secure invalidates tracked by secure sync only
  wire s_sync_start = wr && hit_ssync;
  // Start wins over a done arriving in the same cycle
  wire ns_sync_nxt = ns_sync_start | (ns_sync_r & ~ns_inv_done);
  wire s_sync_nxt = s_sync_start | (s_sync_r & ~s_inv_done);

  // Attribute field only used when type says it is defined
  // Type change applies stored attribute one cycle after the type is stored
  wire attr_defined = mfmt_r[SARB_TYPE_LSB +: 2] == SARB_TYPE_ATTR;
  wire [3:0] attr_code = attr_defined ? mfmt_r[SARB_ATTR_LSB +: 4] : 4'h0;
  wire sarb_attr_s attr_nxt = decode_attr(attr_code);

  wire [31:0] rd_nxt =
    hit_sctrl1 ? {21'h0, gasr_r, 10'h0} :
    hit_sstat ? {31'h0, s_sync_r} :
    hit_nsctrl0 ? ns_ctrl0_r :
    // Index only via secure alias read
    hit_nssyn1 ? {16'h0, ssd_r} :
    hit_nsstat ? {31'h0, ns_sync_r} :
    hit_nsats ? {31'h0, ats_s2_r} :
    // Reserved bits read back stored value
    hit_mfmt ? mfmt_r : SARB_ZERO;

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gasr_r <= SARB_GASR_RST;
      ns_ctrl0_r <= SARB_CTRL0_RST;
      mfmt_r <= SARB_MFMT_RST;
    end else if (wr) begin
      if (hit_sctrl1) begin
        gasr_r <= wd[SARB_GASR_BIT];
      end
      if (hit_nsctrl0) begin
        ns_ctrl0_r <= wd;
      end
      if (hit_mfmt) begin
        mfmt_r <= wd;
      end
    end
  end

  // Status inputs from same-clock engines
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ssd_r <= 16'h0;
      ats_s1_r <= 1'b0;
      ats_s2_r <= 1'b0;
    end else begin
      ats_s1_r <= ns_ats_busy;
      ats_s2_r <= ats_s1_r;
      // Index taken with the fault that carries it
      if (ns_fault_valid) begin
        ssd_r <= ns_fault_security_state_determination_index;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ns_sync_r <= 1'b0;
      s_sync_r <= 1'b0;
      ns_issue_r <= 1'b0;
      s_issue_r <= 1'b0;
      rdata_r <= SARB_ZERO;
      rvalid_r <= 1'b0;
      attr_out <= '0;
    end else begin
      ns_sync_r <= ns_sync_nxt;
      s_sync_r <= s_sync_nxt;
      ns_issue_r <= ns_sync_start;
      s_issue_r <= s_sync_start;
      rvalid_r <= cfg_req.valid && !cfg_req.write;
      rdata_r <= rd ? rd_nxt : SARB_ZERO;
      attr_out <= attr_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = rvalid_r;
  assign ns_inv_issue = ns_issue_r;
  assign s_inv_issue = s_issue_r;
  assign ns_sync_active = ns_sync_r;
  assign s_sync_active = s_sync_r;
  assign secure_only_global_access = gasr_r;

  // ==========================================================================
  // Checks
  a_ns_blocked_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.write && !cfg_req.secure && gasr_r) |=> cfg_rdata == 32'h0)
    else $error("non-secure read passed gate");
  a_gasr_reset: assert property (@(posedge ref_clk)
    !rst_b |-> gasr_r == 1'b0) else $error("gate bit not zero in reset");
  a_alias_ns_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cfg_req.valid && !cfg_req.secure && is_alias) |=> cfg_rdata == 32'h0)
    else $error("alias visible to non-secure");
  sequence s_ns_sync_launch;
    ns_inv_issue && ns_sync_active;
  endsequence
  a_sync_issue: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ns_sync_start |=> s_ns_sync_launch) else $error("sync not issued");
  a_sync_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ns_sync_active && !ns_inv_done && !ns_sync_start) |=> ns_sync_active)
    else $error("sync dropped early");
  a_ns_no_sinv: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cfg_req.valid && cfg_req.write && !cfg_req.secure) |=> !s_inv_issue)
    else $error("non-secure started secure invalidate");
  a_attr_decode: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (attr_defined && mfmt_r[7:4] == 4'h2) |=> attr_out.inner == SARB_DEV_NGRE)
    else $error("device attribute wrong");
  a_attr_rsvd: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (attr_defined && mfmt_r[7:4] == 4'hC) |=> attr_out.inner == SARB_NORM_RSVD && attr_out.normal)
    else $error("reserved normal encoding wrong");
  a_mfmt_store: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr && hit_mfmt) |=> mfmt_r == $past(cfg_req.wdata)) else $error("field not stored");
  a_rsvd_inert: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !attr_defined |=> attr_out == '0) else $error("reserved field leaked");

endmodule : sarb_regbank

// ---- design/sarb_pkg.sv ----
// Package for the secure alias and attribute register bank
package sarb_pkg;

  // ==========================================================================
  // Widths and configuration-space offsets (byte address, one 32-bit register per 4 bytes)
  localparam int SARB_AW = 12;
  localparam int SARB_DW = 32;
  localparam logic [11:0] SARB_OFF_SCTRL1 = 12'h004;
  localparam logic [11:0] SARB_OFF_STLB_SYNC = 12'h070;
  localparam logic [11:0] SARB_OFF_STLB_STAT = 12'h074;
  localparam logic [11:0] SARB_OFF_NS_CTRL0 = 12'h400;
  localparam logic [11:0] SARB_OFF_NS_SYN1 = 12'h454;
  localparam logic [11:0] SARB_OFF_NS_TLB_SYNC = 12'h470;
  localparam logic [11:0] SARB_OFF_NS_TLB_STAT = 12'h474;
  localparam logic [11:0] SARB_OFF_NS_ATS_STAT = 12'h478;
  localparam logic [11:0] SARB_OFF_MFMT = 12'h480;

  // ==========================================================================
  // Field positions and reset values
  localparam int SARB_GASR_BIT = 10;
  localparam int SARB_ACTIVE_BIT = 0;
  localparam int SARB_TYPE_LSB = 0;
  localparam int SARB_ATTR_LSB = 4;
  localparam logic SARB_GASR_RST = 1'b0;
  localparam logic [31:0] SARB_ZERO = 32'h0000_0000;
  localparam logic [31:0] SARB_MFMT_RST = 32'h0000_0000;
  localparam logic [31:0] SARB_CTRL0_RST = 32'h0000_0001;
  localparam logic [1:0] SARB_TYPE_ATTR = 2'h1;

  // ==========================================================================
  // Decoded memory attributes
  typedef enum logic [2:0] {
    SARB_DEV_NGNRNE, SARB_DEV_NGNRE, SARB_DEV_NGRE, SARB_DEV_GRE,
    SARB_NORM_NC, SARB_NORM_WT, SARB_NORM_WB, SARB_NORM_RSVD
  } sarb_mtype_e;

  typedef struct packed {
    logic normal;
    sarb_mtype_e inner;
    logic [1:0] outer;
  } sarb_attr_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sarb_req_s;

endpackage : sarb_pkg

// ---- tb/tb_secure_alias_attr_regbank.sv ----
// Self-checking bench for the secure alias and attribute register bank
module tb_secure_alias_attr_regbank;
  timeunit 1ns;
  timeprecision 1ps;
  import sarb_pkg::*;
  // ====================
  // Signals
  logic ref_clk, rst_b, cfg_rvalid, ns_fault_valid, ns_inv_done, s_inv_done, ns_ats_busy;
  logic ns_inv_issue, s_inv_issue, ns_sync_active, s_sync_active, secure_only_global_access;
  logic [31:0] cfg_rdata, lfsr, d;
  logic [15:0] ns_fault_security_state_determination_index, idx;
  sarb_req_s cfg_req;
  sarb_attr_s attr_out;
  int fails, n_checks;
  sarb_regbank DUT (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .ns_fault_security_state_determination_index(ns_fault_security_state_determination_index),
    .ns_fault_valid(ns_fault_valid), .ns_inv_done(ns_inv_done), .s_inv_done(s_inv_done),
    .ns_ats_busy(ns_ats_busy), .ns_inv_issue(ns_inv_issue), .s_inv_issue(s_inv_issue),
    .ns_sync_active(ns_sync_active), .s_sync_active(s_sync_active),
    .secure_only_global_access(secure_only_global_access), .attr_out(attr_out));
  // ====================
  // Helpers
  function automatic logic [31:0] rnd();
    lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'h8020_0003 : 32'h0000_0000);
    return lfsr;
  endfunction : rnd
  function automatic sarb_attr_s exp_attr(input logic [3:0] c);
    sarb_attr_s e;
    e.outer = c[3:2];
    e.normal = (c[3:2] != 2'h0);
    if (!e.normal) e.inner = sarb_mtype_e'({1'b0, c[1:0]});
    else if (c[1:0] == 2'h0) e.inner = SARB_NORM_RSVD;
    else e.inner = sarb_mtype_e'(3'h3 + {1'b0, c[1:0]});
    return e;
  endfunction : exp_attr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // One access; read data taken once the answer is flagged
  task automatic acc(input logic w, input logic s, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    tick(1);
    cfg_req = '{valid: 1'b1, write: w, secure: s, addr: a, wdata: wd};
    tick(1);
    cfg_req.valid = 1'b0;
    if (!w && cfg_rvalid !== 1'b1) tick(1);
    if (!w) check(32'(cfg_rvalid), 32'h1);
    rd = cfg_rdata;
  endtask : acc
  task automatic wr(input logic s, input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] v;
    acc(1'b1, s, a, wd, v);
  endtask : wr
  task automatic rdchk(input logic s, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    acc(1'b0, s, a, 32'h0000_0000, v);
    check(v, exp);
  endtask : rdchk
  // Runs one sync; the opposite world must stay silent
  task automatic sync_test(input logic ns);
    logic [11:0] so;
    int k;
    so = ns ? SARB_OFF_NS_TLB_SYNC : SARB_OFF_STLB_SYNC;
    wr(1'b1, so, rnd());
    k = 0;
    while ((ns ? ns_inv_issue : s_inv_issue) !== 1'b1 && k < 4) begin
      tick(1);
      k++;
    end
    check(32'(k < 4), 32'h1);
    check(32'(ns ? s_inv_issue : ns_inv_issue), 32'h0);
    rdchk(1'b1, so + 12'h004, 32'h1);
    if (ns) ns_inv_done = 1'b1;
    else s_inv_done = 1'b1;
    tick(1);
    ns_inv_done = 1'b0;
    s_inv_done = 1'b0;
    tick(2);
    check(32'(ns ? ns_sync_active : s_sync_active), 32'h0);
    rdchk(1'b1, so + 12'h004, 32'h0);
  endtask : sync_test
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // ====================
  // Clock, watchdog and sequence
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #50000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    lfsr = 32'h0000_0011;
    {rst_b, ns_fault_valid, ns_inv_done, s_inv_done, ns_ats_busy} = '0;
    cfg_req = '0;
    ns_fault_security_state_determination_index = 16'h0000;
    tick(3);
    rst_b = 1'b1;
    check(32'(secure_only_global_access), 32'(SARB_GASR_RST));
    rdchk(1'b1, SARB_OFF_NS_CTRL0, SARB_CTRL0_RST);
    rdchk(1'b0, SARB_OFF_NS_CTRL0, SARB_ZERO);
    rdchk(1'b1, SARB_OFF_MFMT, SARB_MFMT_RST);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      d = rnd();
      d[7:4] = 4'(c);
      if (d[1:0] == SARB_TYPE_ATTR) d[1:0] = 2'h3;
      wr(1'b1, SARB_OFF_MFMT, d);
      rdchk(1'b1, SARB_OFF_MFMT, d);
      check(32'(attr_out), 32'h0000_0000);
      d[1:0] = SARB_TYPE_ATTR;
      wr(1'b1, SARB_OFF_MFMT, d);
      tick(2);
      check(32'(attr_out), 32'(exp_attr(4'(c))));
    end
    $display("test attribute decode done");
    wr(1'b1, SARB_OFF_SCTRL1, 32'h0000_0400);
    tick(1);
    check(32'(secure_only_global_access), 32'h1);
    rdchk(1'b0, SARB_OFF_MFMT, SARB_ZERO);
    wr(1'b0, SARB_OFF_MFMT, rnd());
    wr(1'b0, SARB_OFF_SCTRL1, SARB_ZERO);
    rdchk(1'b1, SARB_OFF_MFMT, d);
    wr(1'b1, SARB_OFF_SCTRL1, SARB_ZERO);
    rdchk(1'b0, SARB_OFF_MFMT, d);
    $display("test access gate done");
    idx = 16'(rnd());
    ns_fault_security_state_determination_index = idx;
    ns_fault_valid = 1'b1;
    tick(1);
    ns_fault_valid = 1'b0;
    tick(4);
    ns_fault_security_state_determination_index = ~idx;
    rdchk(1'b1, SARB_OFF_NS_SYN1, {16'h0000, idx});
    rdchk(1'b0, SARB_OFF_NS_SYN1, SARB_ZERO);
    wr(1'b0, SARB_OFF_NS_TLB_SYNC, rnd());
    tick(2);
    check(32'(ns_sync_active), 32'h0);
    sync_test(1'b1);
    sync_test(1'b0);
    $display("test sync done");
    ns_ats_busy = 1'b1;
    tick(4);
    rdchk(1'b1, SARB_OFF_NS_ATS_STAT, 32'h1);
    ns_ats_busy = 1'b0;
    tick(4);
    rdchk(1'b1, SARB_OFF_NS_ATS_STAT, 32'h0);
    $display("test translation status done");
    wr(1'b1, SARB_OFF_SCTRL1, 32'h0000_0400);
    rst_b = 1'b0;
    tick(1);
    rst_b = 1'b1;
    check(32'(secure_only_global_access), 32'(SARB_GASR_RST));
    d = rnd();
    wr(1'b0, SARB_OFF_MFMT, d);
    rdchk(1'b0, SARB_OFF_MFMT, d);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : tb_secure_alias_attr_regbank
